// >>> design/ivad_top.sv
`timescale 1ns/10ps
`include "ivad_defines.svh"
module ivad_top
    import ivad_pkg::*;
(
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    // Configuration
    input  wire logic                     boot_reset_fuse_i,
    // Control writes
    input  wire logic                     ctl_wr_i,
    input  wire logic                     vector_change_enable_i,
    input  wire logic                     vector_table_in_boot_i,
    // Interrupt requests, already enabled and synchronous
    input  wire logic [`IVAD_NUM_IRQ-1:0] irq_req_i,
    input  wire logic                     irq_ack_i,
    // Fetch address to the program counter
    output logic                          fetch_valid_o,
    output ivad_addr_t                    fetch_addr_o,
    output ivad_idx_t                     irq_idx_o,
    output logic                          vector_table_in_boot_o,
    output logic                          irq_blocked_o
);
    typedef struct packed {
        ivad_state_t st;
        logic        valid;
        ivad_addr_t  addr;
        ivad_idx_t   idx;
        logic [1:0]  fuse_sync;
        logic        vsel;
        logic        blk;
    } ivad_top_t;

    ivad_top_t s_q, s_d;
    logic      any_req;
    ivad_idx_t win_idx;
    logic      vsel;
    logic      chg_open;
    ivad_addr_t base;

    ivad_prio_enc u_prio (
        .req_i (irq_req_i),
        .any_o (any_req),
        .idx_o (win_idx)
    );

    ivad_vec_chg u_chg (
        .sys_clk_i              (sys_clk_i),
        .rst_i                  (rst_i),
        .ctl_wr_i               (ctl_wr_i),
        .vector_change_enable_i (vector_change_enable_i),
        .vector_table_in_boot_i (vector_table_in_boot_i),
        .vector_table_in_boot_o (vsel),
        .chg_open_o             (chg_open)
    );

    // Table base follows only the select bit; fuse has no say here
    assign base = vsel ? `IVAD_BOOT_ADDR : `IVAD_RESET_ADDR; // [R10] [R11] [R13]

    always_comb begin
        s_d      = s_q;
        s_d.vsel = vsel;
        // Requests are held off while a table move is pending
        s_d.blk  = chg_open;
        // Fuse strap passes two flops; they run through reset so the value is settled at release
        s_d.fuse_sync = {s_q.fuse_sync[0], boot_reset_fuse_i};
        case (s_q.st)
            IVAD_ST_RESET: begin
                s_d.valid = 1'b1;
                s_d.idx   = '0;
                if (s_q.fuse_sync[1] == `IVAD_FUSE_PROG) begin
                    s_d.addr = `IVAD_BOOT_ADDR; // [R9] [R12] [R13]
                end else begin
                    s_d.addr = `IVAD_RESET_ADDR; // [R1] [R12]
                end
                s_d.st = IVAD_ST_IRQ;
            end
            IVAD_ST_IRQ: begin
                // Hold the reset vector until the core takes it
                if (irq_ack_i) begin
                    s_d.valid = 1'b0;
                    s_d.st    = IVAD_ST_IDLE;
                end
            end
            IVAD_ST_IDLE: begin
                if (s_q.valid) begin
                    if (irq_ack_i) begin
                        s_d.valid = 1'b0;
                    end
                end else if (any_req && !chg_open) begin
                    s_d.valid = 1'b1;
                    s_d.idx   = win_idx; // [R15]
                    // Slot n+1 sits two words per vector above the base
                    s_d.addr  = base + (ivad_addr_t'(win_idx) + 14'h0001) * `IVAD_SLOT_WORDS; // [R2] [R3] [R4] [R5] [R6] [R7] [R8]
                end
            end
            default: begin
                s_d.st = IVAD_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q.st    <= IVAD_ST_RESET;
            s_q.valid <= 1'b0;
            s_q.addr  <= `IVAD_RESET_ADDR;
            s_q.idx   <= '0;
            s_q.fuse_sync <= s_d.fuse_sync;
            s_q.vsel  <= `IVAD_VSEL_RESET;
            s_q.blk   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fetch_valid_o          = s_q.valid;
    assign fetch_addr_o           = s_q.addr;
    assign irq_idx_o              = s_q.idx;
    assign vector_table_in_boot_o = s_q.vsel;
    assign irq_blocked_o          = s_q.blk;
endmodule // ivad_top

// >>> design/ivad_defines.svh
// Operation
// [R1] With the boot-reset fuse unprogrammed, reset fetches from vector 1 at address 0x0000.
// [R2] External request 0 vectors to 0x0002 and external request 1 to 0x0004.
// [R3] Pin change requests 0, 1 and 2 vector to 0x0006, 0x0008 and 0x000A.
// [R4] Watchdog time-out vectors to 0x000C, timer 2 match A, B and wrap to 0x000E..0x0012.
// [R5] Timer 1 capture, match A, match B and wrap vector to 0x0014..0x001A.
// [R6] Timer 0 match A, match B and wrap vector to 0x001C, 0x001E and 0x0020.
// [R7] Serial peripheral done is 0x0022; USART receive, empty, transmit are 0x0024..0x0028.
// [R8] ADC 0x002A, EEPROM ready 0x002C, comparator 0x002E, two-wire 0x0030, self-program 0x0032.
// [R9] With the boot-reset fuse programmed, every reset fetches from the boot reset address.
// [R10] With the vector table in boot, each vector is the nominal address plus the boot start.
// [R11] The vector table base depends only on the table-in-boot bit, never on the fuse.
// [R12] Fuse value 1 means unprogrammed (reset at zero), value 0 programmed (boot address).
// [R13] With a 2 Kbyte boot section the boot reset address is 0x1C00, vectors 0x1C02..0x1C32.
// [R14] The table-in-boot bit changes only if written within four cycles of the change enable.
// [R15] Among several pending enabled requests the lowest vector number wins.
`ifndef IVAD_DEFINES_SVH
`define IVAD_DEFINES_SVH

`define IVAD_ADDR_W        14
`define IVAD_NUM_IRQ       25
`define IVAD_IDX_W         5
`define IVAD_RESET_ADDR    14'h0000
`define IVAD_BOOT_ADDR     14'h1C00
`define IVAD_SLOT_WORDS    14'h0002
`define IVAD_FUSE_PROG     1'b0
`define IVAD_CHG_CYCLES    3'h4
`define IVAD_VSEL_RESET    1'b0

`endif

// >>> design/ivad_pkg.sv
`include "ivad_defines.svh"
package ivad_pkg;
    typedef logic [`IVAD_ADDR_W-1:0] ivad_addr_t;
    typedef logic [`IVAD_IDX_W-1:0]  ivad_idx_t;
    typedef enum logic [2:0] {
        IVAD_ST_IDLE  = 3'b001,
        IVAD_ST_RESET = 3'b010,
        IVAD_ST_IRQ   = 3'b100
    } ivad_state_t;
endpackage

// >>> design/ivad_prio_enc.sv
`timescale 1ns/10ps
`include "ivad_defines.svh"
module ivad_prio_enc
    import ivad_pkg::*;
(
    // Requests, bit 0 is external request 0
    input  wire logic [`IVAD_NUM_IRQ-1:0] req_i,
    // Winner
    output logic                          any_o,
    output ivad_idx_t                     idx_o
);
    always_comb begin
        any_o = 1'b0;
        idx_o = '0;
        // Scan downward so the lowest index is the last to win
        for (int i = `IVAD_NUM_IRQ - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                idx_o = ivad_idx_t'(i); // [R15]
            end
        end
    end
endmodule // ivad_prio_enc

// >>> design/ivad_vec_chg.sv
`timescale 1ns/10ps
`include "ivad_defines.svh"
module ivad_vec_chg
    import ivad_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Control write strobe from the core
    input  wire logic ctl_wr_i,
    input  wire logic vector_change_enable_i,
    input  wire logic vector_table_in_boot_i,
    // State
    output logic      vector_table_in_boot_o,
    output logic      chg_open_o
);
    typedef struct packed {
        logic       vsel;
        logic [2:0] cnt;
    } ivad_chg_t;

    ivad_chg_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (s_q.cnt != 3'h0) begin
            s_d.cnt = s_q.cnt - 3'h1;
        end
        if (ctl_wr_i) begin
            if (vector_change_enable_i) begin
                // Enable opens the window; value is not taken on this write
                s_d.cnt = `IVAD_CHG_CYCLES;
            end else if (s_q.cnt != 3'h0) begin
                s_d.vsel = vector_table_in_boot_i; // [R14]
                s_d.cnt  = 3'h0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q <= '{vsel: `IVAD_VSEL_RESET, cnt: 3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign vector_table_in_boot_o = s_q.vsel;
    assign chg_open_o             = s_q.cnt != 3'h0;
endmodule // ivad_vec_chg

// >>> verification/ivad_chk.sv
`timescale 1ns/10ps
module ivad_chk
    import ivad_pkg::*;
(
    // Watched ports
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        boot_reset_fuse_i,
    input wire logic        ctl_wr_i,
    input wire logic        vector_change_enable_i,
    input wire logic        vector_table_in_boot_i,
    input wire logic [24:0] irq_req_i,
    input wire logic        irq_ack_i,
    input wire logic        fetch_valid_o,
    input wire ivad_addr_t  fetch_addr_o,
    input wire ivad_idx_t   irq_idx_o,
    input wire logic        vector_table_in_boot_o,
    input wire logic        irq_blocked_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    rst_vec_a: assert property ($fell(rst_i) |-> ##[1:2] fetch_valid_o
        && fetch_addr_o == (boot_reset_fuse_i ? 14'h0000 : 14'h1C00))
        else $error("wrong reset fetch");
    fetch_hold_a: assert property (fetch_valid_o && !irq_ack_i |=> fetch_valid_o
        && $stable(fetch_addr_o) && $stable(irq_idx_o))
        else $error("fetch dropped before ack");
    ack_drop_a: assert property (fetch_valid_o && irq_ack_i |=> !fetch_valid_o)
        else $error("fetch stays after ack");
    irq_serve_a: assert property (!fetch_valid_o && |irq_req_i && !irq_blocked_o
        |-> ##[1:6] fetch_valid_o)
        else $error("request not served");
    vec_map_a: assert property (fetch_valid_o && irq_idx_o != 5'h00 |-> fetch_addr_o ==
        (vector_table_in_boot_o ? 14'h1C00 : 14'h0000) + 14'h0002 * (irq_idx_o + 14'h0001))
        else $error("vector address wrong");
    low_wins_a: assert property ($rose(fetch_valid_o) |->
        ($past(irq_req_i) & ((25'h0000001 << irq_idx_o) - 25'h0000001)) == 25'h0000000)
        else $error("lower request skipped");
    win_open_a: assert property (ctl_wr_i && vector_change_enable_i |-> ##[1:2] irq_blocked_o)
        else $error("change window not shown");
    sel_change_a: assert property ($changed(vector_table_in_boot_o) |->
        $past(ctl_wr_i && !vector_change_enable_i && vector_table_in_boot_i, 2)
        == vector_table_in_boot_o)
        else $error("select changed without write");
endmodule // ivad_chk

bind ivad_top ivad_chk ivad_chk_i (.*);

// >>> verification/ivad_core_model.sv
`timescale 1ns/10ps
module ivad_core_model (
    // Fetch handshake
    input  wire logic       sys_clk_i,
    input  wire logic       fetch_valid_i,
    input  wire logic [2:0] delay_i,
    output logic            irq_ack_o
);
    logic [2:0] wait_q;
    initial irq_ack_o = 1'b0;
    initial wait_q = 3'h0;
    // Slow acks keep the fetch standing for several cycles
    always @(posedge sys_clk_i) begin
        if (fetch_valid_i && !irq_ack_o && wait_q >= delay_i) begin
            irq_ack_o <= #1 1'b1;
            wait_q <= 3'h0;
        end else begin
            irq_ack_o <= #1 1'b0;
            wait_q <= fetch_valid_i ? wait_q + 3'h1 : 3'h0;
        end
    end
endmodule // ivad_core_model

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import ivad_pkg::*;
;
    logic        sys_clk_i, rst_i, boot_reset_fuse_i, ctl_wr_i, irq_ack_i;
    logic        vector_change_enable_i, vector_table_in_boot_i;
    logic [24:0] irq_req_i, r;
    logic        fetch_valid_o, vector_table_in_boot_o, irq_blocked_o;
    ivad_addr_t  fetch_addr_o;
    ivad_idx_t   irq_idx_o;
    logic [2:0]  delay;
    logic [31:0] seed;
    int          num_errors, checked, waited;
    ivad_top ivad_top_i (.*);
    ivad_core_model ivad_core_model_i (.sys_clk_i(sys_clk_i), .fetch_valid_i(fetch_valid_o),
        .delay_i(delay), .irq_ack_o(irq_ack_i));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic ivad_addr_t va(input logic sel, input ivad_idx_t i);
        return (sel ? 14'h1C00 : 14'h0000) + 14'h0002 * (14'(i) + 14'h0001);
    endfunction
    function automatic ivad_idx_t low(input logic [24:0] q);
        for (int i = 24; i >= 0; i--)
            if (q[i]) low = 5'(i);
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask
    // Request is held until the core has acked, as a level source would
    task automatic take(input logic [24:0] req, input ivad_idx_t i, input ivad_addr_t a);
        int n;
        n = 0;
        seed = lfsr(seed);
        delay = seed[2:0];
        irq_req_i = req;
        for (; fetch_valid_o !== 1'b1 && n < 40; n++) step();
        waited = n;
        check({irq_idx_o, fetch_addr_o}, {i, a});
        for (; fetch_valid_o !== 1'b0 && n < 40; n++) step();
        irq_req_i = '0;
        step();
        if (n >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic move(input logic sel, input logic arm, input logic exp);
        ctl_wr_i = 1'b1;
        vector_change_enable_i = arm;
        vector_table_in_boot_i = ~sel;
        step();
        vector_change_enable_i = 1'b0;
        vector_table_in_boot_i = sel;
        step();
        check(19'(irq_blocked_o), 19'(arm));
        ctl_wr_i = 1'b0;
        repeat (6) step();
        check(19'(vector_table_in_boot_o), 19'(exp));
        check(19'(irq_blocked_o), 19'h0);
    endtask
    // Enable write with no select write: a request waits out the four-cycle window
    task automatic lapse(input ivad_idx_t i);
        ctl_wr_i = 1'b1;
        vector_change_enable_i = 1'b1;
        step();
        ctl_wr_i = 1'b0;
        vector_change_enable_i = 1'b0;
        take(25'h1 << i, i, va(1'b1, i));
        check(19'(waited), 19'h5);
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        print_verdict();
    end
    initial begin
        {ctl_wr_i, vector_change_enable_i, vector_table_in_boot_i} = 3'h0;
        irq_req_i = '0;
        delay = 3'h0;
        seed = 32'hD316;
        num_errors = 0;
        checked = 0;
        for (int f = 1; f >= 0; f--) begin
            boot_reset_fuse_i = f[0];
            rst_i = 1'b1;
            repeat (4) step();
            rst_i = 1'b0;
            take('0, 5'h00, f ? 14'h0000 : 14'h1C00);
            for (int v = 0; v < 2; v++) begin
                move(v[0], 1'b1, v[0]);
                for (int i = 0; i < 25; i++)
                    take(25'h1 << i, 5'(i), va(v[0], 5'(i)));
            end
            move(1'b0, 1'b0, 1'b1);
            lapse(5'(seed % 32'd25));
            for (int k = 0; k < 20; k++) begin
                r = seed[24:0] | 25'h1000000;
                take(r, low(r), va(1'b1, low(r)));
            end
            $display("test with fuse %0d done", f);
        end
        print_verdict();
    end
endmodule // tb_top
